// *** design/wdtc_pkg.sv ***
// constants for the second watchdog timer: register map, fields, key codes
// assumes an 8-bit register port and a 100 MHz system clock
package wdtc_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   localparam int CNT_W  = 19;
   localparam int EXP_W  = 3;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_MODE  = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_KEY   = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_OSC   = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_STAT  = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_MASK  = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_STATE = 3'h5;

   // ----------------------------------------
   // fields and values
   // ----------------------------------------
   localparam int MODE_RESET_BIT = 6;   // 1: reset mode, 0: interrupt mode
   localparam int SEL_OSC_BIT    = 3;   // 1: internal oscillator clock
   localparam int OSC_STOP_BIT   = 0;
   localparam int STAT_OVF_BIT   = 0;   // counter ran out
   localparam int STAT_FORCE_BIT = 1;   // bad key or repeated mode write
   localparam int STAT_W         = 2;
   localparam logic [DATA_W-1:0] MODE_RESET_VAL = 8'h47;  // reset mode, 2^19 clocks
   localparam logic [DATA_W-1:0] STOP_CODE      = 8'h1F;
   localparam logic [DATA_W-1:0] KEY_CLEAR      = 8'hAC;
   localparam logic [DATA_W-1:0] KEY_READ       = 8'h9A;
   localparam logic [4:0]        EXP_BASE       = 5'h0C;  // shortest interval 2^12
endpackage

// *** design/wdtc_cnt_if.sv ***
// link between the watchdog control and its interval counter
// assumes both ends share one clock
`timescale 1ns/10ps
interface wdtc_cnt_if;
   import wdtc_pkg::*;
   logic             clear;
   logic             tick;
   logic [EXP_W-1:0] expSel;
   logic             overflow;
   logic [CNT_W-1:0] count;

   modport ctrl (output clear, output tick, output expSel, input overflow, input count);
   modport cnt  (input clear, input tick, input expSel, output overflow, output count);
endinterface

// *** design/wdtc_counter.sv ***
// interval counter of the watchdog: counts enabled ticks, pulses on overflow
// assumes clear and tick come from logic on the same clock
`timescale 1ns/10ps
module wdtc_counter
   import wdtc_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   wdtc_cnt_if.cnt   link
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             ovf;
   } wdtc_cnt_state_t;

   wdtc_cnt_state_t st;
   wdtc_cnt_state_t next_st;
   logic [CNT_W-1:0] limit;

   // terminal count 2^(12+sel)-1
   assign limit = CNT_W'((20'h1 << (EXP_BASE + 5'(link.expSel))) - 20'h1);
   assign link.overflow = st.ovf;
   assign link.count    = st.cnt;

   always_comb begin
      next_st     = st;
      next_st.ovf = 1'b0;
      if (link.clear) begin
         next_st.cnt = '0;
      end else if (link.tick) begin
         if (st.cnt >= limit) begin
            next_st.cnt = '0;
            next_st.ovf = 1'b1;
         end else begin
            next_st.cnt = st.cnt + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_wrap_count: assert property (@(posedge clk) disable iff (reset)
      link.tick && !link.clear && st.cnt == limit |=> st.ovf && st.cnt == '0)
      else $error("counter did not wrap with overflow");
endmodule

// *** design/wdtc_top.sv ***
// second watchdog timer: mode and key registers, forced overflow, lock strap
// assumes a one-cycle register port; oscillator clock and strap are async pins
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps

module wdtc_top
   import wdtc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [DATA_W-1:0] rdata,
   input  wire logic              internalOscClock,
   input  wire logic              optionLockBit,
   output logic                   chipResetRequest,
   output logic                   watchdogNmiRequest,
   output logic                   irq
);
   typedef struct packed {
      logic [DATA_W-1:0] modeReg;
      logic              modeWritten;
      logic              stopped;
      logic              oscStop;
      logic [STAT_W-1:0] status;
      logic [STAT_W-1:0] mask;
      logic [DATA_W-1:0] rdata;
      logic              resetReq;
      logic              nmiReq;
      logic              irq;
      logic [1:0]        oscSync;
      logic              oscPrev;
      logic [1:0]        lockSync;
   } wdtc_state_t;

   localparam wdtc_state_t ST_RESET = '{modeReg: MODE_RESET_VAL, default: '0};

   wdtc_state_t st;
   wdtc_state_t next_st;
   wdtc_cnt_if  cntLink ();

   logic oscTick;
   logic lockOn;
   logic useOsc;
   logic modeWr;
   logic keyWr;
   logic keyGood;
   logic forceEv;
   logic resetMode;
   logic [STAT_W-1:0] setBits;
   logic [STAT_W-1:0] clrBits;

   wdtc_counter u_counter (
      .clk   (clk),
      .reset (reset),
      .link  (cntLink)
   );

   // ----------------------------------------
   // clock selection and strap
   // ----------------------------------------
   assign oscTick   = st.oscSync[1] & ~st.oscPrev;
   assign lockOn    = st.lockSync[1];
   assign useOsc    = lockOn | st.modeReg[SEL_OSC_BIT];
   assign resetMode = lockOn | st.modeReg[MODE_RESET_BIT];
   assign cntLink.tick   = st.stopped ? 1'b0 : (useOsc ? oscTick : 1'b1);
   assign cntLink.expSel = st.modeReg[EXP_W-1:0];

   assign modeWr  = wr && addr == ADDR_MODE;
   assign keyWr   = wr && addr == ADDR_KEY;
   assign keyGood = keyWr && wdata == KEY_CLEAR;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_st          = st;
      next_st.rdata    = '0;
      next_st.resetReq = 1'b0;
      next_st.nmiReq   = 1'b0;
      next_st.oscSync  = {st.oscSync[0], internalOscClock};
      next_st.oscPrev  = st.oscSync[1];
      next_st.lockSync = {st.lockSync[0], optionLockBit};
      next_st.stopped  = st.stopped & ~lockOn;
      forceEv          = 1'b0;
      cntLink.clear    = 1'b0;
      clrBits          = '0;

      if (modeWr) begin
         if (!st.modeWritten) begin
            next_st.modeWritten = 1'b1;
            next_st.modeReg     = wdata;
            cntLink.clear       = 1'b1;
            if (lockOn) begin
               next_st.modeReg[MODE_RESET_BIT] = 1'b1;
               next_st.modeReg[SEL_OSC_BIT]    = 1'b1;
            end else if (wdata == STOP_CODE && st.oscStop) begin
               next_st.stopped = 1'b1;
            end
         end else if (!st.stopped) begin
            forceEv       = 1'b1;
            cntLink.clear = 1'b1;
         end
      end

      if (keyWr) begin
         if (keyGood) begin
            cntLink.clear = 1'b1;
         end else if (!st.stopped) begin
            forceEv = 1'b1;
         end
      end

      if (wr && addr == ADDR_OSC) begin
         next_st.oscStop = wdata[OSC_STOP_BIT];
      end
      if (wr && addr == ADDR_MASK) begin
         next_st.mask = wdata[STAT_W-1:0];
      end
      if (wr && addr == ADDR_STAT) begin
         clrBits = wdata[STAT_W-1:0];
      end

      // set wins over a same-cycle clear
      setBits = '0;
      setBits[STAT_OVF_BIT]   = cntLink.overflow;
      setBits[STAT_FORCE_BIT] = forceEv;
      next_st.status = (st.status & ~clrBits) | setBits;

      if (cntLink.overflow || forceEv) begin
         if (resetMode) begin
            next_st.resetReq = 1'b1;
         end else begin
            next_st.nmiReq = 1'b1;
         end
      end
      next_st.irq = |(next_st.status & next_st.mask);

      if (rd) begin
         case (addr)
            ADDR_MODE:  next_st.rdata = st.modeReg;
            ADDR_KEY:   next_st.rdata = KEY_READ;
            ADDR_OSC:   next_st.rdata = DATA_W'(st.oscStop);
            ADDR_STAT:  next_st.rdata = DATA_W'(st.status);
            ADDR_MASK:  next_st.rdata = DATA_W'(st.mask);
            ADDR_STATE: next_st.rdata = DATA_W'({lockOn, st.stopped, st.modeWritten});
            default:    next_st.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign rdata              = st.rdata;
   assign chipResetRequest   = st.resetReq;
   assign watchdogNmiRequest = st.nmiReq;
   assign irq                = st.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_first_write;
      modeWr && !st.modeWritten;
   endsequence

   sequence s_second_write;
      modeWr && st.modeWritten && !st.stopped;
   endsequence

   a_second_write: assert property (s_second_write
      |=> (chipResetRequest || watchdogNmiRequest) && cntLink.count == '0)
      else $error("second mode write did not force overflow");
   a_mode_kept: assert property (s_second_write
      |=> st.modeReg == $past(st.modeReg))
      else $error("repeated mode write was stored");
   a_lock_store: assert property (s_first_write ##0 lockOn
      |=> st.modeReg[MODE_RESET_BIT] && st.modeReg[SEL_OSC_BIT])
      else $error("locked mode write left interrupt mode selectable");
   a_key_quiet: assert property (keyGood && !cntLink.overflow
      |=> !chipResetRequest && !watchdogNmiRequest)
      else $error("good key raised an overflow request");
   a_ovf_status: assert property (cntLink.overflow
      |=> st.status[STAT_OVF_BIT])
      else $error("overflow did not set its status bit");
   a_bad_key: assert property (keyWr && !keyGood && !st.stopped
      |=> (chipResetRequest || watchdogNmiRequest) && st.status[STAT_FORCE_BIT])
      else $error("bad key did not force overflow");
   a_good_key: assert property (keyGood |=> cntLink.count == '0 && !st.status[STAT_FORCE_BIT]
      || $past(st.status[STAT_FORCE_BIT]))
      else $error("good key did not clear counter");
   a_stop_quiet: assert property (st.stopped && (modeWr || keyWr)
      |=> !chipResetRequest && !watchdogNmiRequest)
      else $error("stopped watchdog forced overflow");
   a_lock_no_nmi: assert property (lockOn && $past(lockOn) |-> !watchdogNmiRequest)
      else $error("nmi raised while locked in reset mode");
   a_lock_no_stop: assert property (lockOn |=> !st.stopped)
      else $error("locked watchdog was stopped");
   a_lock_osc_clk: assert property (lockOn && !st.stopped |-> cntLink.tick == oscTick)
      else $error("locked watchdog not on oscillator clock");
   a_ovf_route: assert property (cntLink.overflow
      |=> chipResetRequest == $past(resetMode) && watchdogNmiRequest != $past(resetMode))
      else $error("overflow routed to the wrong output");
endmodule

// *** tb/wdtc_tb.sv ***
// self-checking bench for the second watchdog timer, driven over its register port
// assumes the design package, interface and modules are compiled first
`timescale 1ns/10ps
module tb;
   import wdtc_pkg::*;
   logic              clk              = 1'b0;
   logic              reset            = 1'b1;
   logic [ADDR_W-1:0] addr             = '0;
   logic [DATA_W-1:0] wdata            = '0;
   logic              wr               = 1'b0;
   logic              rd               = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              internalOscClock = 1'b0;
   logic              optionLockBit    = 1'b0;
   logic              chipResetRequest;
   logic              watchdogNmiRequest;
   logic              irq;
   logic [1:0]        oscDiv           = 2'h0;
   int                miscompares      = 0;
   int                cmp_count        = 0;
   int                n;

   // ----------------------------------------
   // clocks and design
   // ----------------------------------------
   always #5 clk = ~clk;

   // oscillator clock at a quarter of the system clock
   always @(posedge clk) begin
      oscDiv <= oscDiv + 2'h1;
      if (oscDiv[0]) begin
         internalOscClock <= ~internalOscClock;
      end
   end

   wdtc_top uut (
      .clk                (clk),
      .reset              (reset),
      .addr               (addr),
      .wdata              (wdata),
      .wr                 (wr),
      .rd                 (rd),
      .rdata              (rdata),
      .internalOscClock   (internalOscClock),
      .optionLockBit      (optionLockBit),
      .chipResetRequest   (chipResetRequest),
      .watchdogNmiRequest (watchdogNmiRequest),
      .irq                (irq)
   );

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic give_verdict();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask

   // request pulse in the cycle after a write, gone one cycle later
   task automatic pulse_chk(input logic r, input logic m);
      #1 chk({6'h0, chipResetRequest, watchdogNmiRequest}, {6'h0, r, m});
      @(posedge clk);
      #1 chk({6'h0, chipResetRequest, watchdogNmiRequest}, 8'h00);
   endtask

   task automatic wait_req(input int lim, input bit must);
      n = 0;
      while (chipResetRequest !== 1'b1 && watchdogNmiRequest !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
      if (must && n >= lim) begin
         miscompares++;
         give_verdict();
      end
   endtask

   task automatic do_reset(input logic lock);
      @(posedge clk);
      optionLockBit <= lock;
      reset         <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      // strap synchroniser restarts from zero after reset
      repeat (2) @(posedge clk);
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd_chk(ADDR_MODE, MODE_RESET_VAL);
      rd_chk(ADDR_KEY, KEY_READ);
      rd_chk(ADDR_MASK, 8'h00);
      wr_reg(3'h7, 8'hFF);
      rd_chk(3'h7, 8'h00);
      wr_reg(ADDR_MODE, 8'h40);
      pulse_chk(1'b0, 1'b0);
      wr_reg(ADDR_MASK, 8'h03);
      wr_reg(ADDR_KEY, 8'h00);
      pulse_chk(1'b1, 1'b0);
      chk({7'h0, irq}, 8'h01);
      rd_chk(ADDR_STAT, 8'h02);
      wr_reg(ADDR_STAT, 8'h02);
      rd_chk(ADDR_STAT, 8'h00);
      chk({7'h0, irq}, 8'h00);
      wr_reg(ADDR_MASK, 8'h00);
      wr_reg(ADDR_MODE, 8'h47);
      pulse_chk(1'b1, 1'b0);
      rd_chk(ADDR_MODE, 8'h40);
      chk({7'h0, irq}, 8'h00);
      rd_chk(ADDR_STAT, 8'h02);
      wr_reg(ADDR_STAT, 8'h03);
      wait_req(3000, 1'b0);
      chk({7'h0, n == 3000}, 8'h01);
      wr_reg(ADDR_KEY, KEY_CLEAR);
      pulse_chk(1'b0, 1'b0);
      wait_req(5000, 1'b1);
      chk({7'h0, n >= 4090 && n <= 4100}, 8'h01);
      rd_chk(ADDR_STAT, 8'h01);
      // interrupt mode
      do_reset(1'b0);
      wr_reg(ADDR_MODE, 8'h00);
      wr_reg(ADDR_KEY, 8'h55);
      pulse_chk(1'b0, 1'b1);
      // stopped watchdog
      do_reset(1'b0);
      wr_reg(ADDR_OSC, 8'h01);
      rd_chk(ADDR_OSC, 8'h01);
      wr_reg(ADDR_MODE, STOP_CODE);
      rd_chk(ADDR_STATE, 8'h03);
      wr_reg(ADDR_KEY, 8'h00);
      pulse_chk(1'b0, 1'b0);
      wr_reg(ADDR_MODE, 8'h40);
      pulse_chk(1'b0, 1'b0);
      rd_chk(ADDR_STAT, 8'h00);
      // locked strap
      do_reset(1'b1);
      rd_chk(ADDR_STATE, 8'h04);
      wr_reg(ADDR_OSC, 8'h01);
      wr_reg(ADDR_MODE, STOP_CODE);
      rd_chk(ADDR_STATE, 8'h05);
      rd_chk(ADDR_MODE, 8'h5F);
      wr_reg(ADDR_KEY, 8'h00);
      pulse_chk(1'b1, 1'b0);
      do_reset(1'b1);
      wr_reg(ADDR_MODE, 8'h00);
      rd_chk(ADDR_MODE, 8'h48);
      wait_req(17000, 1'b1);
      chk({7'h0, n >= 16370 && n <= 16400}, 8'h01);
      chk({6'h0, chipResetRequest, watchdogNmiRequest}, 8'h02);
      give_verdict();
   end
endmodule
